// File: bench/mem_partner.sv
// Far-side model: SDRAM pair, async memories and wait-capable peripherals
`timescale 1ns/1ps
module mem_partner (
   // Clock and wait setting
   input  wire logic        core_clk,
   input  wire logic [7:0]  wait_n,
   // SDRAM pins
   input  wire logic        mem_clock_enable,
   input  wire logic        mem_row_strobe_n,
   input  wire logic        mem_col_strobe_n,
   input  wire logic        mem_write_strobe_n,
   input  wire logic        mem_select_a_n,
   input  wire logic        mem_select_b_n,
   input  wire logic        upper_byte_mask,
   input  wire logic        lower_byte_mask,
   input  wire logic [1:0]  mem_bank,
   input  wire logic [12:0] mem_addr,
   // Shared bus
   input  wire logic        rd_wr_n,
   input  wire logic        out_enable_n,
   input  wire logic [15:0] data_out,
   input  wire logic        data_oe,
   output logic      [15:0] data_in,
   // Async selects and peripheral strobes
   input  wire logic        async_select_a_n,
   input  wire logic        async_select_b_n,
   input  wire logic        periph_a_read_strobe,
   input  wire logic        periph_a_write_strobe,
   input  wire logic        periph_b_read_strobe,
   input  wire logic        periph_b_write_strobe,
   output logic             periph_wait_ready
);
   logic [15:0] sd_mem [logic [24:0]];
   logic [12:0] row_q [8];
   logic [15:0] amem [2];
   logic [15:0] preg [2];
   logic [15:0] rd_word_q;
   logic [15:0] old;
   logic [15:0] last_q    = 16'h5555;
   logic [3:0]  rd_pipe_q = 4'h0;
   logic [7:0]  wcnt_q    = 8'h00;
   logic        dev;
   logic        any_stb;
   logic [3:0]  cmd;
   logic [24:0] key;

   // ==================================================================
   // Command decode
   assign dev = ~mem_select_b_n;
   assign cmd = {mem_select_a_n & mem_select_b_n, mem_row_strobe_n,
                 mem_col_strobe_n, mem_write_strobe_n};
   assign key = {dev, mem_bank, row_q[{dev, mem_bank}], mem_addr[8:0]};
   assign any_stb = ~(periph_a_read_strobe & periph_a_write_strobe &
                      periph_b_read_strobe & periph_b_write_strobe);

   always @(posedge core_clk) begin
      last_q <= data_in;
      rd_pipe_q <= {rd_pipe_q[2:0], 1'b0};
      wcnt_q <= any_stb ? wcnt_q + 8'h01 : 8'h00;
      if (mem_clock_enable) begin
         if (cmd == 4'h3) row_q[{dev, mem_bank}] <= mem_addr;
         if (cmd == 4'h4) begin
            old = sd_mem.exists(key) ? sd_mem[key] : 16'h0000;
            sd_mem[key] = {upper_byte_mask ? old[15:8] : data_out[15:8],
                           lower_byte_mask ? old[7:0] : data_out[7:0]};
         end
         if (cmd == 4'h5) begin
            rd_word_q <= sd_mem.exists(key) ? sd_mem[key] : ~last_q;
            rd_pipe_q <= 4'h1;
         end
      end
      if (!async_select_a_n && !rd_wr_n && data_oe) amem[0] <= data_out;
      if (!async_select_b_n && !rd_wr_n && data_oe) amem[1] <= data_out;
      if (!periph_a_write_strobe) preg[0] <= data_out;
      if (!periph_b_write_strobe) preg[1] <= data_out;
   end

   // Released bus shows the inverse of the last word, never a held value
   always_comb begin
      periph_wait_ready = !(any_stb && wcnt_q < wait_n);
      data_in = ~last_q;
      if (rd_pipe_q[1] | rd_pipe_q[2]) data_in = rd_word_q;
      else if (!out_enable_n && !async_select_a_n) data_in = amem[0];
      else if (!out_enable_n && !async_select_b_n) data_in = amem[1];
      else if (!periph_a_read_strobe) data_in = preg[0];
      else if (!periph_b_read_strobe) data_in = preg[1];
   end
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the external memory bus interface
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic        wr;
      logic [1:0]  tg;
      logic        ub;
      logic [24:0] ad;
      logic [15:0] wd;
      logic [1:0]  be;
      logic [15:0] ex;
   } row_s;

   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid, req_ready, req_write, req_unit_b, rsp_valid;
   logic [1:0] req_target, req_byte_en, mem_bank;
   logic [ebi_pkg::ADDR_W-1:0] req_addr;
   logic [ebi_pkg::DATA_W-1:0] req_wdata, rsp_rdata, data_out, data_in;
   logic sel_b_as_gpio, gpio_out, mem_clk, mem_clock_enable;
   logic mem_row_strobe_n, mem_col_strobe_n, mem_write_strobe_n;
   logic mem_select_a_n, mem_select_b_n, upper_byte_mask, lower_byte_mask;
   logic [ebi_pkg::MEM_ADDR_W-1:0] mem_addr;
   logic rd_wr_n, out_enable_n, data_oe, buffer_enable_a, buffer_enable_b;
   logic async_select_a_n, async_select_b_n, periph_wait_ready;
   logic periph_a_read_strobe, periph_a_write_strobe;
   logic periph_b_read_strobe, periph_b_write_strobe;
   logic [7:0] wait_n;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;

   row_s rows [16] = '{
      '{1'b1, 2'h0, 1'b0, 25'h000_0a05, 16'haaaa, 2'h3, 16'h0000},
      '{1'b1, 2'h0, 1'b0, 25'h000_0a05, 16'h1234, 2'h1, 16'h0000},
      '{1'b0, 2'h0, 1'b0, 25'h000_0a05, 16'h0000, 2'h3, 16'haa34},
      '{1'b1, 2'h0, 1'b0, 25'h100_3a05, 16'h5a5a, 2'h3, 16'h0000},
      '{1'b0, 2'h0, 1'b0, 25'h100_3a05, 16'h0000, 2'h3, 16'h5a5a},
      '{1'b0, 2'h0, 1'b0, 25'h000_0a05, 16'h0000, 2'h3, 16'haa34},
      '{1'b1, 2'h0, 1'b0, 25'h1ff_ffff, 16'h8001, 2'h3, 16'h0000},
      '{1'b0, 2'h0, 1'b0, 25'h1ff_ffff, 16'h0000, 2'h3, 16'h8001},
      '{1'b1, 2'h1, 1'b0, 25'h000_0010, 16'hc3c3, 2'h3, 16'h0000},
      '{1'b1, 2'h1, 1'b1, 25'h000_0010, 16'h3c3c, 2'h3, 16'h0000},
      '{1'b0, 2'h1, 1'b0, 25'h000_0010, 16'h0000, 2'h3, 16'hc3c3},
      '{1'b0, 2'h1, 1'b1, 25'h000_0010, 16'h0000, 2'h3, 16'h3c3c},
      '{1'b1, 2'h2, 1'b0, 25'h000_0004, 16'h0f0f, 2'h3, 16'h0000},
      '{1'b1, 2'h2, 1'b1, 25'h000_0004, 16'hf0f0, 2'h3, 16'h0000},
      '{1'b0, 2'h2, 1'b0, 25'h000_0004, 16'h0000, 2'h3, 16'h0f0f},
      '{1'b0, 2'h2, 1'b1, 25'h000_0004, 16'h0000, 2'h3, 16'hf0f0}};

   ext_bus_if dut_u (.core_clk, .rst_n, .req_valid, .req_ready, .req_write,
      .req_target, .req_unit_b, .req_addr, .req_wdata, .req_byte_en,
      .rsp_valid, .rsp_rdata, .sel_b_as_gpio, .gpio_out, .mem_clk,
      .mem_clock_enable, .mem_row_strobe_n, .mem_col_strobe_n,
      .mem_write_strobe_n, .mem_select_a_n, .mem_select_b_n,
      .upper_byte_mask, .lower_byte_mask, .mem_bank, .mem_addr, .rd_wr_n,
      .out_enable_n, .data_out, .data_oe, .data_in, .buffer_enable_a,
      .buffer_enable_b, .async_select_a_n, .async_select_b_n,
      .periph_wait_ready, .periph_a_read_strobe, .periph_a_write_strobe,
      .periph_b_read_strobe, .periph_b_write_strobe);

   mem_partner partner_u (.core_clk, .wait_n, .mem_clock_enable,
      .mem_row_strobe_n, .mem_col_strobe_n, .mem_write_strobe_n,
      .mem_select_a_n, .mem_select_b_n, .upper_byte_mask, .lower_byte_mask,
      .mem_bank, .mem_addr, .rd_wr_n, .out_enable_n, .data_out, .data_oe,
      .data_in, .async_select_a_n, .async_select_b_n, .periph_a_read_strobe,
      .periph_a_write_strobe, .periph_b_read_strobe, .periph_b_write_strobe,
      .periph_wait_ready);

   // ==================================================================
   // Clock, timeout and reporting
   always #(ebi_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   // A full run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic close_out();
      $display("errors %0d, checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask

   // Pin activity seen during one access, one bit per pin
   function automatic logic [13:0] pins();
      return {data_oe, ~mem_write_strobe_n, ~mem_select_b_n, ~mem_select_a_n,
              ~periph_b_write_strobe, ~periph_b_read_strobe,
              ~periph_a_write_strobe, ~periph_a_read_strobe,
              ~async_select_b_n, ~async_select_a_n, buffer_enable_b,
              buffer_enable_a, ~out_enable_n, ~rd_wr_n};
   endfunction

   function automatic logic [13:0] exp_pins(row_s r);
      logic sd, as, pe, b;
      sd = r.tg == 2'h0;
      as = r.tg == 2'h1;
      pe = r.tg == 2'h2;
      b = sd ? r.ad[24] : r.ub;
      return {r.wr, sd & r.wr, sd & b, sd & !b, pe & b & r.wr, pe & b & !r.wr,
              pe & !b & r.wr, pe & !b & !r.wr, as & b, as & !b, pe, sd | as,
              as & !r.wr, r.wr};
   endfunction

   // Async select stands two cycles; a ready peripheral answers in three
   function automatic int exp_lat(row_s r);
      if (r.tg != 2'h0) return (r.tg == 2'h1) ? 2 : 3;
      return ebi_pkg::TRCD_CYC + 1 +
             (r.wr ? ebi_pkg::TRP_CYC : ebi_pkg::CAS_LAT);
   endfunction

   task automatic do_req(input row_s r, output logic [15:0] rd,
                         output int lat, output logic [13:0] ob);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      req_valid = 1'b1;
      req_write = r.wr;
      req_target = r.tg;
      req_unit_b = r.ub;
      req_addr = r.ad;
      req_wdata = r.wd;
      req_byte_en = r.be;
      @(negedge core_clk);
      req_valid = 1'b0;
      check(req_ready, 1'b0);
      lat = 0;
      ob = 14'h0000;
      while (rsp_valid !== 1'b1 && lat < 60) begin
         ob = ob | pins();
         @(negedge core_clk);
         lat++;
      end
      ob = ob | pins();
      rd = rsp_rdata;
      if (r.tg == 2'h0) begin
         @(negedge core_clk);
         check(req_ready, 1'b0);
      end
   endtask

   // ==================================================================
   // Main sequence
   initial begin
      logic [15:0] rd;
      int lat;
      logic [13:0] ob;
      {req_valid, req_write, req_unit_b, sel_b_as_gpio, gpio_out} = 5'h00;
      req_target = 2'h0;
      req_byte_en = 2'h3;
      req_addr = '0;
      req_wdata = 16'h0000;
      wait_n = 8'h00;
      repeat (10) @(negedge core_clk);
      check({mem_clock_enable, data_oe, mem_row_strobe_n, mem_col_strobe_n,
             mem_write_strobe_n, mem_select_a_n, mem_select_b_n}, 7'h1f);
      check(mem_clk, core_clk);
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      check(mem_clock_enable, 1'b1);
      foreach (rows[i]) begin
         do_req(rows[i], rd, lat, ob);
         check(lat, exp_lat(rows[i]));
         check(ob, exp_pins(rows[i]));
         if (!rows[i].wr) check(rd, rows[i].ex);
      end
      // Peripheral held off by not-ready stretches both directions
      wait_n = 8'h05;
      do_req(rows[13], rd, lat, ob);
      check(lat, 8);
      do_req(rows[15], rd, lat, ob);
      check(lat, 8);
      check(rd, 16'hf0f0);
      wait_n = 8'h00;
      sel_b_as_gpio = 1'b1;
      gpio_out = 1'b1;
      @(negedge core_clk);
      check(mem_select_b_n, 1'b1);
      gpio_out = 1'b0;
      @(negedge core_clk);
      check(mem_select_b_n, 1'b0);
      sel_b_as_gpio = 1'b0;
      // Reset in mid-run, then memory contents still read back
      @(negedge core_clk);
      rst_n = 1'b0;
      @(negedge core_clk);
      check({mem_clock_enable, mem_row_strobe_n, mem_col_strobe_n,
             periph_a_read_strobe, periph_b_write_strobe}, 5'h0f);
      rst_n = 1'b1;
      @(negedge core_clk);
      do_req(rows[2], rd, lat, ob);
      check(rd, 16'haa34);
      close_out();
   end
endmodule

// File: hdl/ebi_pkg.sv
// Shared constants and types for the external memory bus interface
package ebi_pkg;

   // =====================================================================
   // Widths
   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 25;          // 32 Mwords of 16 bits = 64 MB
   localparam int MEM_ADDR_W = 13;
   localparam int COL_W      = 9;
   localparam int BANK_W     = 2;
   localparam int ROW_W      = 13;

   // =====================================================================
   // Address field positions (word address)
   localparam int COL_LSB  = 0;
   localparam int BANK_LSB = COL_W;
   localparam int ROW_LSB  = COL_W + BANK_W;
   localparam int SEL_BIT  = COL_W + BANK_W + ROW_W;   // device select

   // Column address bit 10 carries auto-precharge
   localparam int AP_BIT = 10;

   // =====================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int TRCD_NS       = 20;
   localparam int TRP_NS        = 20;
   localparam int CAS_LAT       = 2;
   localparam int TRCD_CYC = (TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRP_CYC  = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE  = 4'h1;

   // =====================================================================
   // Memory command codes {select_n, row_n, col_n, write_n}
   localparam logic [3:0] CMD_NOP   = 4'h7;
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_READ  = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_DESEL = 4'hF;

   // =====================================================================
   // Target spaces of a request
   typedef enum logic [1:0] {
      TGT_SDRAM = 2'h0,
      TGT_ASYNC = 2'h1,
      TGT_PERIPH = 2'h2
   } target_e;

endpackage

// File: hdl/ext_bus_if.sv
// External memory bus interface: SDRAM, async selects, peripherals
`timescale 1ns/1ps
module ext_bus_if (
   // Clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         rst_n,
   // Processor request (processor-initiated only, no DMA port)
   input  wire logic                         req_valid,
   output logic                              req_ready,
   input  wire logic                         req_write,
   input  wire logic [1:0]                   req_target,
   input  wire logic                         req_unit_b,
   input  wire logic [ebi_pkg::ADDR_W-1:0]   req_addr,
   input  wire logic [ebi_pkg::DATA_W-1:0]   req_wdata,
   input  wire logic [1:0]                   req_byte_en,
   output logic                              rsp_valid,
   output logic [ebi_pkg::DATA_W-1:0]        rsp_rdata,
   // Pin function
   input  wire logic                         sel_b_as_gpio,
   input  wire logic                         gpio_out,
   // SDRAM pins
   output logic                              mem_clk,
   output logic                              mem_clock_enable,
   output logic                              mem_row_strobe_n,
   output logic                              mem_col_strobe_n,
   output logic                              mem_write_strobe_n,
   output logic                              mem_select_a_n,
   output logic                              mem_select_b_n,
   output logic                              upper_byte_mask,
   output logic                              lower_byte_mask,
   output logic [1:0]                        mem_bank,
   output logic [ebi_pkg::MEM_ADDR_W-1:0]    mem_addr,
   // Shared bus pins
   output logic                              rd_wr_n,
   output logic                              out_enable_n,
   output logic [ebi_pkg::DATA_W-1:0]        data_out,
   output logic                              data_oe,
   input  wire logic [ebi_pkg::DATA_W-1:0]   data_in,
   output logic                              buffer_enable_a,
   output logic                              buffer_enable_b,
   // Async memory selects
   output logic                              async_select_a_n,
   output logic                              async_select_b_n,
   // Peripheral pins
   input  wire logic                         periph_wait_ready,
   output logic                              periph_a_read_strobe,
   output logic                              periph_a_write_strobe,
   output logic                              periph_b_read_strobe,
   output logic                              periph_b_write_strobe
);

   typedef enum logic [6:0] {
      S_IDLE   = 7'h01,
      S_ACT    = 7'h02,
      S_CMD    = 7'h04,
      S_WAIT   = 7'h08,
      S_PRE    = 7'h10,
      S_ASYNC  = 7'h20,
      S_PERIPH = 7'h40
   } state_e;

   typedef struct packed {
      state_e                          st;
      logic [3:0]                      cnt;
      logic [3:0]                      cmd;
      logic                            write;
      logic                            unit_b;
      logic                            dev_b;
      logic [ebi_pkg::ADDR_W-1:0]      addr;
      logic [1:0]                      be;
      logic [ebi_pkg::DATA_W-1:0]      wdata;
      logic [1:0]                      bank;
      logic [ebi_pkg::MEM_ADDR_W-1:0]  maddr;
      logic                            drive;
      logic                            rsp;
      logic [ebi_pkg::DATA_W-1:0]      rdata;
      logic                            cke;
   } st_s;

   st_s s_q, s_d;

   periph_if pif ();

   periph_strobe u_strobe (
      .core_clk              (core_clk),
      .rst_n                 (rst_n),
      .pif                   (pif.strobe),
      .periph_wait_ready     (periph_wait_ready),
      .periph_a_read_strobe  (periph_a_read_strobe),
      .periph_a_write_strobe (periph_a_write_strobe),
      .periph_b_read_strobe  (periph_b_read_strobe),
      .periph_b_write_strobe (periph_b_write_strobe)
   );

   // Row and column images of a word address
   function automatic logic [ebi_pkg::MEM_ADDR_W-1:0] row_of(
         input logic [ebi_pkg::ADDR_W-1:0] a);
      row_of = a[ebi_pkg::ROW_LSB +: ebi_pkg::ROW_W];
   endfunction

   function automatic logic [ebi_pkg::MEM_ADDR_W-1:0] col_of(
         input logic [ebi_pkg::ADDR_W-1:0] a);
      logic [ebi_pkg::MEM_ADDR_W-1:0] c;
      c = '0;
      c[ebi_pkg::COL_W-1:0] = a[ebi_pkg::COL_LSB +: ebi_pkg::COL_W];
      c[ebi_pkg::AP_BIT]    = 1'b1;
      col_of = c;
   endfunction

   // =====================================================================
   // Sequencer
   always_comb begin
      s_d     = s_q;
      // Idle cycles deselect, so select a, and select b unless sel_b_as_gpio, only mark real commands
      s_d.cmd = ebi_pkg::CMD_DESEL;
      s_d.rsp = 1'b0;
      s_d.cke = 1'b1;
      if (s_q.cnt != ebi_pkg::CNT_ZERO) begin
         s_d.cnt = s_q.cnt - ebi_pkg::CNT_ONE;
      end
      pif.start  = 1'b0;
      pif.write  = s_q.write;
      pif.unit_b = s_q.unit_b;
      unique case (s_q.st)
         S_IDLE: begin
            s_d.drive = 1'b0;
            if (req_valid) begin
               s_d.write  = req_write;
               s_d.unit_b = req_unit_b;
               s_d.addr   = req_addr;
               s_d.be     = req_byte_en;
               s_d.wdata  = req_wdata;
               s_d.dev_b  = req_addr[ebi_pkg::SEL_BIT];
               s_d.drive  = req_write;
               if (req_target == ebi_pkg::TGT_SDRAM) begin
                  s_d.st    = S_ACT;
                  s_d.cmd   = ebi_pkg::CMD_ACT;
                  s_d.bank  = req_addr[ebi_pkg::BANK_LSB +: ebi_pkg::BANK_W];
                  s_d.maddr = row_of(req_addr);
                  s_d.cnt   = 4'(ebi_pkg::TRCD_CYC);
               end else if (req_target == ebi_pkg::TGT_ASYNC) begin
                  s_d.st  = S_ASYNC;
                  s_d.cnt = ebi_pkg::CNT_ONE;
               end else begin
                  s_d.st = S_PERIPH;
               end
            end
         end
         S_ACT: begin
            if (s_q.cnt <= ebi_pkg::CNT_ONE) begin
               s_d.st    = S_CMD;
               // Auto-precharge avoids tracking open rows
               s_d.cmd   = s_q.write ? ebi_pkg::CMD_WRITE
                                     : ebi_pkg::CMD_READ;
               s_d.maddr = col_of(s_q.addr);
               s_d.cnt   = s_q.write ? 4'(ebi_pkg::TRP_CYC)
                                     : 4'(ebi_pkg::CAS_LAT);
            end
         end
         S_CMD: begin
            s_d.drive = 1'b0;
            s_d.st    = S_WAIT;
         end
         S_WAIT: begin
            if (s_q.cnt == ebi_pkg::CNT_ZERO) begin
               if (!s_q.write) begin
                  s_d.rdata = data_in;
               end
               s_d.rsp = 1'b1;
               s_d.st  = S_PRE;
               s_d.cnt = 4'(ebi_pkg::TRP_CYC);
            end
         end
         S_PRE: begin
            if (s_q.cnt == ebi_pkg::CNT_ZERO) begin
               s_d.st = S_IDLE;
            end
         end
         S_ASYNC: begin
            if (s_q.cnt == ebi_pkg::CNT_ZERO) begin
               if (!s_q.write) begin
                  s_d.rdata = data_in;
               end
               s_d.rsp   = 1'b1;
               s_d.drive = 1'b0;
               s_d.st    = S_IDLE;
            end
         end
         S_PERIPH: begin
            pif.start = !pif.busy && !pif.done;
            // Data is only valid while the read strobe is still low
            if (pif.busy && periph_wait_ready && !s_q.write) begin
               s_d.rdata = data_in;
            end
            if (pif.done) begin
               s_d.rsp   = 1'b1;
               s_d.drive = 1'b0;
               s_d.st    = S_IDLE;
            end
         end
         default: begin
            s_d.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q     <= '0;
         s_q.st  <= S_IDLE;
         s_q.cmd <= ebi_pkg::CMD_DESEL;
      end else begin
         s_q <= s_d;
      end
   end

   // =====================================================================
   // Pins
   assign req_ready = (s_q.st == S_IDLE);
   assign rsp_valid = s_q.rsp;
   assign rsp_rdata = s_q.rdata;

   // The SDRAM runs off the bus clock itself
   assign mem_clk            = core_clk;
   assign mem_clock_enable   = s_q.cke;
   assign mem_row_strobe_n   = s_q.cmd[2];
   assign mem_col_strobe_n   = s_q.cmd[1];
   assign mem_write_strobe_n = s_q.cmd[0];
   assign mem_select_a_n     = s_q.cmd[3] | s_q.dev_b;
   assign mem_select_b_n     = sel_b_as_gpio ? gpio_out
                               : (s_q.cmd[3] | ~s_q.dev_b);
   assign upper_byte_mask    = ~s_q.be[1];
   assign lower_byte_mask    = ~s_q.be[0];
   assign mem_bank           = s_q.bank;
   assign mem_addr           = s_q.maddr;

   wire busy_any = (s_q.st != S_IDLE);
   assign rd_wr_n      = ~(busy_any & s_q.write);
   assign out_enable_n = ~((s_q.st == S_ASYNC) & ~s_q.write);
   assign data_out     = s_q.wdata;
   assign data_oe      = s_q.drive;
   assign async_select_a_n = ~((s_q.st == S_ASYNC) & ~s_q.unit_b);
   assign async_select_b_n = ~((s_q.st == S_ASYNC) &  s_q.unit_b);
   // Buffer a serves memories, b the peripherals
   assign buffer_enable_a = busy_any & (s_q.st != S_PERIPH);
   assign buffer_enable_b = (s_q.st == S_PERIPH);

   // =====================================================================
   // Checks
   act_then_cmd_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      s_q.cmd == ebi_pkg::CMD_ACT |-> ##[1:4]
      (s_q.cmd == ebi_pkg::CMD_READ || s_q.cmd == ebi_pkg::CMD_WRITE))
      else $error("column command missing after activate");
   write_strobe_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !s_q.write && busy_any |-> mem_write_strobe_n)
      else $error("write strobe low during read");
   rw_line_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      s_q.st == S_ASYNC |-> rd_wr_n == !s_q.write)
      else $error("read/write line wrong");
   oe_read_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !out_enable_n |-> !s_q.write && !async_select_a_n ^ !async_select_b_n)
      else $error("output enable outside async read");
   select_excl_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !sel_b_as_gpio |-> mem_select_a_n || mem_select_b_n)
      else $error("both SDRAM selects low");
   gpio_pin_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      sel_b_as_gpio |-> mem_select_b_n == gpio_out)
      else $error("select b not following gpio");
   cke_high_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      $rose(rst_n) ##1 1'b1 |-> mem_clock_enable)
      else $error("clock enable low");
   write_drive_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      s_q.cmd == ebi_pkg::CMD_WRITE |-> data_oe)
      else $error("data not driven on write");
   row_addr_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      s_q.cmd == ebi_pkg::CMD_ACT |-> mem_addr == row_of(s_q.addr))
      else $error("row address wrong");

endmodule

// File: hdl/periph_if.sv
// Handshake between the bus engine and the peripheral strobe unit
`timescale 1ns/1ps
interface periph_if;
   logic start;
   logic write;
   logic unit_b;
   logic busy;
   logic done;

   modport engine (output start, output write, output unit_b,
                   input busy, input done);
   modport strobe (input start, input write, input unit_b,
                   output busy, output done);
endinterface

// File: hdl/periph_strobe.sv
// Strobe generator for the two wait-capable peripherals
`timescale 1ns/1ps
module periph_strobe (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Engine side
   periph_if.strobe  pif,
   // Pins
   input  wire logic periph_wait_ready,
   output logic      periph_a_read_strobe,
   output logic      periph_a_write_strobe,
   output logic      periph_b_read_strobe,
   output logic      periph_b_write_strobe
);

   typedef struct packed {
      logic active;
      logic write;
      logic unit_b;
      logic done;
   } st_s;

   st_s s_q, s_d;

   // =====================================================================
   // Next state
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (!s_q.active && pif.start) begin
         s_d.active = 1'b1;
         s_d.write  = pif.write;
         s_d.unit_b = pif.unit_b;
      end else if (s_q.active && periph_wait_ready) begin
         // Not ready keeps the strobe low; ready ends the access
         s_d.active = 1'b0;
         s_d.done   = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pif.busy = s_q.active;
   assign pif.done = s_q.done;

   // Strobes are active low, one per direction and unit
   assign periph_a_read_strobe  = ~(s_q.active & ~s_q.write & ~s_q.unit_b);
   assign periph_a_write_strobe = ~(s_q.active &  s_q.write & ~s_q.unit_b);
   assign periph_b_read_strobe  = ~(s_q.active & ~s_q.write &  s_q.unit_b);
   assign periph_b_write_strobe = ~(s_q.active &  s_q.write &  s_q.unit_b);

   // =====================================================================
   // Checks
   strobe_held_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      s_q.active && !periph_wait_ready |=> s_q.active)
      else $error("strobe released while not ready");
   strobe_end_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      s_q.active && periph_wait_ready |=> !s_q.active && pif.done)
      else $error("strobe not ended on ready");
   one_strobe_a : assert property (@(posedge core_clk)
      disable iff (!rst_n)
      $countones({periph_a_read_strobe, periph_a_write_strobe,
                  periph_b_read_strobe, periph_b_write_strobe}) >= 3)
      else $error("more than one peripheral strobe low");

endmodule
